// >>> rtl/pbsid_defines.svh
// offsets, field positions, fixed values and counts of the status/id block
`ifndef PBSID_DEFINES_SVH
`define PBSID_DEFINES_SVH
`define PBSID_REG_STATUS 5'h01
`define PBSID_REG_ID_HIGH 5'h02
`define PBSID_REG_ID_LOW 5'h03
`define PBSID_BIT_T4 15
`define PBSID_BIT_TXFD 14
`define PBSID_BIT_THD 11
`define PBSID_BIT_PRE 6
`define PBSID_BIT_ANC 5
`define PBSID_BIT_RF 4
`define PBSID_BIT_ANA 3
`define PBSID_BIT_LINK 2
`define PBSID_BIT_JAB 1
`define PBSID_BIT_EXT 0
`define PBSID_LAT_RF 0
`define PBSID_LAT_LINK 1
`define PBSID_LAT_JAB 2
`define PBSID_LAT_LOW_MASK 3'h2
`define PBSID_LAT_RESET 3'h0
`define PBSID_PREAMBLE_LAST 6'h1F
`define PBSID_OP_READ 2'h2
`define PBSID_OP_WRITE 2'h1
`define PBSID_ADDR_LAST 4'h9
`define PBSID_DATA_LAST 4'hF
`define PBSID_ID_HIGH_DEF 16'h5A3C
`define PBSID_OUI_LOW_DEF 6'h2D
`define PBSID_MODEL_DEF 6'h11
`define PBSID_REV_DEF 4'h7
`endif

// >>> rtl/pbsid_pkg.sv
// types shared by the status/id block
package pbsid_pkg;
	typedef logic [4:0] pbsid_addr_t;
	typedef logic [15:0] pbsid_word_t;
	typedef enum logic [2:0] {
		st_hunt, st_start, st_op, st_addr, st_ta, st_data
	} pbsid_state_t;
endpackage : pbsid_pkg

// >>> rtl/pbsid_if.sv
// link between the frame engine and the latched status holder
`timescale 1ns/10ps
interface pbsid_if;
	logic [2:0] evt;
	logic clr;
	logic wipe;
	logic [2:0] shown;
	modport owner(output evt, output clr, output wipe, input shown);
	modport holder(input evt, input clr, input wipe, output shown);
endinterface : pbsid_if

// >>> rtl/pbsid_latch.sv
// latched-high and latched-low status bits, cleared by a status read
`timescale 1ns/10ps
`include "pbsid_defines.svh"
module pbsid_latch #(
	parameter int N = 3,
	parameter logic [N-1:0] LOW_MASK = `PBSID_LAT_LOW_MASK
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	pbsid_if.holder lat
);
	logic [N-1:0] held;
	logic [N-1:0] next_held;
	logic [N-1:0] capture;

	// per bit: catch the event level, keep it until read; set beats clear
	genvar i;
	for (i = 0; i < N; i++) begin : g_bit
		assign capture[i] = LOW_MASK[i] ? !lat.evt[i] : lat.evt[i];
		assign next_held[i] = !lat.wipe &&
			(capture[i] || (held[i] && !lat.clr));
		assign lat.shown[i] = LOW_MASK[i] ? (lat.evt[i] && !held[i])
			: (lat.evt[i] || held[i]);
	end

	// register the held flags
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			held <= `PBSID_LAT_RESET;
		end else begin
			held <= next_held;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	AST_RF_HOLD: assert property (
		(lat.shown[`PBSID_LAT_RF] && !lat.clr && !lat.wipe)
		|=> lat.shown[`PBSID_LAT_RF])
		else $error("remote fault dropped before read");
	AST_JAB_HOLD: assert property (
		(lat.shown[`PBSID_LAT_JAB] && !lat.clr && !lat.wipe)
		|=> lat.shown[`PBSID_LAT_JAB])
		else $error("jabber dropped before read");
	AST_LINK_LOW_HOLD: assert property (
		(!lat.shown[`PBSID_LAT_LINK] && !lat.clr && !lat.wipe)
		|=> !lat.shown[`PBSID_LAT_LINK])
		else $error("link low released before read");
	AST_LINK_LIVE: assert property (
		(lat.clr && lat.evt[`PBSID_LAT_LINK]) ##1 lat.evt[`PBSID_LAT_LINK]
		|-> lat.shown[`PBSID_LAT_LINK])
		else $error("link did not return to live after read");
	AST_LH_RETURN: assert property (
		(lat.clr && !lat.wipe && !lat.evt[`PBSID_LAT_RF])
		##1 !lat.evt[`PBSID_LAT_RF] |-> !lat.shown[`PBSID_LAT_RF])
		else $error("latched high bit not released by read");
endmodule : pbsid_latch

// >>> rtl/pbsid_top.sv
// serial management slave serving the status and identifier registers
`timescale 1ns/10ps
`include "pbsid_defines.svh"
// What this block does
// - status bit 15 always reads zero
// - status bits 14 to 11 read zero
// - preamble suppression reported; 32 ones resynchronise
// - remote fault latches high until read
// - link bit live, loss latched until read
// - jabber latches high until read
// - auto-negotiation ability bit reads zero
// - extended capability bit reads one
// - first identifier returns fixed sixteen bits
// - second identifier packs oui, model, revision
// - latched-high bits clear to live on read
// - latched-low bits clear to live on read
module pbsid_top #(
	parameter logic [15:0] ID_HIGH = `PBSID_ID_HIGH_DEF, // arbitrary value
	parameter logic [5:0] OUI_LOW = `PBSID_OUI_LOW_DEF, // arbitrary value
	parameter logic [5:0] MODEL = `PBSID_MODEL_DEF, // arbitrary value
	parameter logic [3:0] REV = `PBSID_REV_DEF // arbitrary value
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic soft_rst_in,
	input wire pbsid_pkg::pbsid_addr_t phy_addr_in,
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_out,
	input wire logic link_up_in,
	input wire logic remote_fault_in,
	input wire logic jabber_in
);
	import pbsid_pkg::*;

	logic mdc_s1, mdc_s2, mdc_s3;
	logic mdio_s1, mdio_s2;
	pbsid_addr_t strap_s1, strap_s2, phy_addr;
	logic [1:0] strap_age;
	pbsid_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [5:0] ones, next_ones;
	logic synced, next_synced;
	logic [1:0] op, next_op;
	logic [8:0] addr, next_addr;
	pbsid_word_t shadow, next_shadow;
	logic next_out, next_oe;
	logic clr, next_clr;
	logic rise, bit_in, load;
	pbsid_addr_t regad_now;
	pbsid_if lat_if();

	// read value of one register, unmapped offsets read as zero
	function automatic pbsid_word_t read_word(input pbsid_addr_t ra,
			input logic [2:0] sh);
		pbsid_word_t w;
		w = 16'h0000;
		case (ra)
			`PBSID_REG_STATUS: begin
				w[`PBSID_BIT_PRE] = 1'b1;
				w[`PBSID_BIT_ANC] = 1'b1;
				w[`PBSID_BIT_RF] = sh[`PBSID_LAT_RF];
				w[`PBSID_BIT_LINK] = sh[`PBSID_LAT_LINK];
				w[`PBSID_BIT_JAB] = sh[`PBSID_LAT_JAB];
				w[`PBSID_BIT_EXT] = 1'b1;
			end
			`PBSID_REG_ID_HIGH: w = ID_HIGH;
			`PBSID_REG_ID_LOW: w = {OUI_LOW, MODEL, REV};
			default: w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	// pin synchronisers and strap capture after reset release
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mdc_s1 <= 1'b0;
			mdc_s2 <= 1'b0;
			mdc_s3 <= 1'b0;
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
			strap_s1 <= 5'h00;
			strap_s2 <= 5'h00;
			phy_addr <= 5'h00;
			strap_age <= 2'h0;
		end else begin
			mdc_s1 <= mdc_in;
			mdc_s2 <= mdc_s1;
			mdc_s3 <= mdc_s2;
			mdio_s1 <= mdio_in;
			mdio_s2 <= mdio_s1;
			strap_s1 <= phy_addr_in;
			strap_s2 <= strap_s1;
			// take the strap once the second stage holds the pin value
			phy_addr <= (strap_age == 2'h2) ? strap_s2 : phy_addr;
			strap_age <= (strap_age == 2'h3) ? strap_age : strap_age + 2'h1;
		end
	end

	// status events and read-clear toward the latch holder
	assign rise = mdc_s2 && !mdc_s3;
	assign bit_in = mdio_s2;
	assign regad_now = {addr[3:0], bit_in};
	assign load = rise && state == st_addr && cnt == `PBSID_ADDR_LAST &&
		op == `PBSID_OP_READ && addr[8:4] == phy_addr;
	assign lat_if.evt[`PBSID_LAT_RF] = remote_fault_in;
	assign lat_if.evt[`PBSID_LAT_LINK] = link_up_in;
	assign lat_if.evt[`PBSID_LAT_JAB] = jabber_in;
	assign lat_if.clr = clr;
	assign lat_if.wipe = soft_rst_in;

	pbsid_latch #(
		.N(3),
		.LOW_MASK(`PBSID_LAT_LOW_MASK)
	) u_latch (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.lat(lat_if.holder)
	);

	// frame engine: preamble hunt, start, opcode, address, turnaround, data
	always_comb begin
		logic bad;
		bad = 1'b0;
		next_state = state;
		next_cnt = cnt;
		next_ones = ones;
		next_synced = synced;
		next_op = op;
		next_addr = addr;
		next_shadow = shadow;
		next_out = mdio_out;
		next_oe = mdio_oe_out;
		next_clr = 1'b0;
		if (rise) begin
			unique case (state)
				st_hunt: begin
					if (bit_in) begin
						if (ones == `PBSID_PREAMBLE_LAST) begin
							next_synced = 1'b1;
						end else begin
							next_ones = ones + 6'h01;
						end
					end else if (synced) begin
						next_state = st_start;
					end else begin
						next_ones = 6'h00;
					end
				end
				st_start: begin
					next_state = bit_in ? st_op : st_hunt;
					next_cnt = 4'h0;
				end
				st_op: begin
					next_op = {op[0], bit_in};
					if (cnt == 4'h0) begin
						next_cnt = 4'h1;
					end else if (op[0] != bit_in) begin
						next_state = st_addr;
						next_cnt = 4'h0;
					end else begin
						bad = 1'b1;
					end
				end
				st_addr: begin
					// last bit stays out so addr[8:4] keeps the phy address
					if (cnt == `PBSID_ADDR_LAST) begin
						next_state = st_ta;
						next_cnt = 4'h0;
						if (load) begin
							next_shadow = read_word(regad_now, lat_if.shown);
							next_clr = regad_now == `PBSID_REG_STATUS;
						end
					end else begin
						next_addr = {addr[7:0], bit_in};
						next_cnt = cnt + 4'h1;
					end
				end
				st_ta: begin
					if (cnt == 4'h0) begin
						next_cnt = 4'h1;
						if (op == `PBSID_OP_READ) begin
							next_oe = addr[8:4] == phy_addr;
							next_out = 1'b0;
						end else if (!bit_in) begin
							bad = 1'b1;
						end
					end else begin
						next_cnt = 4'h0;
						next_state = st_data;
						if (op == `PBSID_OP_READ) begin
							next_out = shadow[15];
							next_shadow = {shadow[14:0], 1'b0};
						end else if (bit_in) begin
							bad = 1'b1;
						end
					end
				end
				st_data: begin
					// write data is taken and dropped: nothing here is writable
					if (op == `PBSID_OP_READ) begin
						next_out = shadow[15];
						next_shadow = {shadow[14:0], 1'b0};
					end
					if (cnt == `PBSID_DATA_LAST) begin
						next_oe = 1'b0;
						next_out = 1'b0;
						next_state = st_hunt;
						next_ones = 6'h00;
					end else begin
						next_cnt = cnt + 4'h1;
					end
				end
			endcase
			if (bad) begin
				next_state = st_hunt;
				next_synced = 1'b0;
				next_ones = 6'h00;
			end
		end
	end

	// register the frame engine
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state <= st_hunt;
			cnt <= 4'h0;
			ones <= 6'h00;
			synced <= 1'b0;
			op <= 2'h0;
			addr <= 9'h000;
			shadow <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe_out <= 1'b0;
			clr <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ones <= next_ones;
			synced <= next_synced;
			op <= next_op;
			addr <= next_addr;
			shadow <= next_shadow;
			mdio_out <= next_out;
			mdio_oe_out <= next_oe;
			clr <= next_clr;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	AST_T4_ZERO: assert property (
		(load && regad_now == `PBSID_REG_STATUS) |=> shadow[`PBSID_BIT_T4] == 1'b0)
		else $error("four-lane bit not zero");
	AST_TX_ZERO: assert property (
		(load && regad_now == `PBSID_REG_STATUS)
		|=> shadow[`PBSID_BIT_TXFD:`PBSID_BIT_THD] == 4'h0)
		else $error("twisted-pair ability bits not zero");
	AST_PRE_BIT: assert property (
		(load && regad_now == `PBSID_REG_STATUS) |=> shadow[`PBSID_BIT_PRE])
		else $error("preamble suppression bit not set");
	AST_DESYNC: assert property (
		(rise && state == st_op && cnt == 4'h1 && op[0] == bit_in) |=> !synced)
		else $error("bad opcode did not force preamble");
	AST_AN_ABILITY: assert property (
		(load && regad_now == `PBSID_REG_STATUS) |=> !shadow[`PBSID_BIT_ANA])
		else $error("auto-negotiation ability not zero");
	AST_AN_DONE: assert property (
		(load && regad_now == `PBSID_REG_STATUS) |=> shadow[`PBSID_BIT_ANC])
		else $error("auto-negotiation complete not one");
	AST_EXT: assert property (
		(load && regad_now == `PBSID_REG_STATUS) |=> shadow[`PBSID_BIT_EXT])
		else $error("extended capability not one");
	AST_ID_HIGH: assert property (
		(load && regad_now == `PBSID_REG_ID_HIGH) |=> shadow == ID_HIGH)
		else $error("first identifier wrong");
	AST_ID_LOW: assert property (
		(load && regad_now == `PBSID_REG_ID_LOW)
		|=> shadow == {OUI_LOW, MODEL, REV})
		else $error("second identifier wrong");
	AST_NO_WRITE_CLR: assert property (
		clr |-> $past(load) && $past(regad_now) == `PBSID_REG_STATUS)
		else $error("latched bits cleared without a status read");

	COV_STATUS_READ: cover property (load && regad_now == `PBSID_REG_STATUS);
	COV_SYNC: cover property ($rose(synced));
	COV_DESYNC: cover property ($fell(synced));
	COV_WRITE_DONE: cover property (rise && state == st_data &&
		op == `PBSID_OP_WRITE && cnt == `PBSID_DATA_LAST);
endmodule : pbsid_top

// >>> sim/pbsid_mgr.sv
// management station model that drives the serial management pins
`timescale 1ns/10ps
module pbsid_mgr (
	input wire logic clk_sys_in,
	input wire logic mdio_dev_in,
	input wire logic mdio_oe_in,
	output logic mdc_out,
	output logic mdio_out
);
	logic drv_en;
	logic drv_bit;
	// wire level: device first, then station, else the pull-up
	assign mdio_out = mdio_oe_in ? mdio_dev_in : (drv_en ? drv_bit : 1'b1);
	// idle: clock stands low, line released
	initial begin
		mdc_out = 1'b0;
		drv_en = 1'b0;
		drv_bit = 1'b0;
	end
	// one bit: data set with mdc low, rise after 5 clk, wire taken at rise
	task automatic bit_cyc(input logic en, input logic b, output logic s);
		@(posedge clk_sys_in);
		mdc_out <= 1'b0;
		drv_en <= en;
		drv_bit <= b;
		repeat (5) @(posedge clk_sys_in);
		mdc_out <= 1'b1;
		s = mdio_out;
		repeat (4) @(posedge clk_sys_in);
	endtask : bit_cyc
	// whole frame; reads release the line from turnaround on
	task automatic frame(input logic pre, input logic [1:0] op,
		input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic s;
		logic rdop;
		logic [31:0] hdr;
		rdop = (op == 2'h2);
		hdr = {2'h1, op, pa, ra, 2'h2, wd};
		if (pre) begin
			for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
		end
		for (int i = 31; i >= 0; i--) begin
			bit_cyc(!(rdop && i < 18), hdr[i], s);
			if (i < 16) rd[i] = s;
		end
		@(posedge clk_sys_in);
		mdc_out <= 1'b0;
		drv_en <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
	endtask : frame
endmodule : pbsid_mgr

// >>> sim/tb_phy_basic_status_and_id_regs.sv
// self-checking bench for the status and identifier registers
`timescale 1ns/10ps
module tb_phy_basic_status_and_id_regs;
	import pbsid_pkg::*;
	localparam logic [15:0] ID_H = 16'hC3A5; // arbitrary value
	localparam logic [15:0] ID_L = {6'h15, 6'h2A, 4'h9}; // arbitrary value
	localparam pbsid_addr_t ADDR = 5'h05;
	logic clk_sys_in;
	logic rst_n;
	logic soft_rst;
	pbsid_addr_t phy_addr;
	logic mdc;
	logic mdio;
	logic mdio_out;
	logic mdio_oe;
	logic link_up;
	logic remote_fault;
	logic jabber;
	logic h_rf;
	logic h_ll;
	logic h_jab;
	logic [15:0] d;
	logic [31:0] r;
	int seed;
	int num_errors;
	int check_count;
	// device and station
	pbsid_top #(.ID_HIGH(ID_H), .OUI_LOW(ID_L[15:10]), .MODEL(ID_L[9:4]),
		.REV(ID_L[3:0])) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n),
		.soft_rst_in(soft_rst), .phy_addr_in(phy_addr), .mdc_in(mdc),
		.mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe),
		.link_up_in(link_up), .remote_fault_in(remote_fault),
		.jabber_in(jabber));
	pbsid_mgr mgr (.clk_sys_in(clk_sys_in), .mdio_dev_in(mdio_out),
		.mdio_oe_in(mdio_oe), .mdc_out(mdc), .mdio_out(mdio));
	// 50 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	// status word from live levels and the holds seen so far
	function automatic logic [15:0] exp_status();
		return 16'h0061 | {11'h000, remote_fault | h_rf, 1'b0,
			link_up & ~h_ll, jabber | h_jab, 1'b0};
	endfunction : exp_status
	// identifier words, zero elsewhere
	function automatic logic [15:0] id_val(input logic [4:0] ra);
		return (ra == 5'h02) ? ID_H : ((ra == 5'h03) ? ID_L : 16'h0000);
	endfunction : id_val
	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : check
	// apply event levels and note what the holds must keep
	task automatic lev(input logic rf, input logic lk, input logic jb);
		@(posedge clk_sys_in);
		remote_fault <= rf;
		link_up <= lk;
		jabber <= jb;
		repeat (3) @(posedge clk_sys_in);
		h_rf = h_rf | rf;
		h_ll = h_ll | ~lk;
		h_jab = h_jab | jb;
	endtask : lev
	task automatic rdf(input logic pre, input pbsid_addr_t pa,
		input logic [4:0] ra);
		mgr.frame(pre, 2'h2, pa, ra, 16'h0000, d);
	endtask : rdf
	// status read; holds fall back to live afterwards
	task automatic rd_status(input logic pre);
		rdf(pre, ADDR, 5'h01);
		check(d, exp_status());
		// a level still present after the read latches again at once
		h_rf = remote_fault;
		h_ll = ~link_up;
		h_jab = jabber;
	endtask : rd_status
	// verdict and end of run
	task automatic summarize();
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// watchdog against a hung frame
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		num_errors++;
		summarize();
	end
	// main sequence
	initial begin
		seed = 9;
		num_errors = 0;
		check_count = 0;
		{h_rf, h_ll, h_jab} = 3'h0;
		rst_n = 1'b0;
		soft_rst = 1'b0;
		phy_addr = ADDR;
		link_up = 1'b1;
		remote_fault = 1'b0;
		jabber = 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		rdf(1'b0, ADDR, 5'h01);
		check(d, 16'hFFFF);
		rd_status(1'b1);
		rdf(1'b0, ADDR, 5'h02);
		check(d, ID_H);
		rdf(1'b0, ADDR, 5'h03);
		check(d, ID_L);
		rdf(1'b0, ADDR, 5'h00);
		check(d, 16'h0000);
		// events held through writes and a foreign address
		lev(1'b1, 1'b0, 1'b1);
		lev(1'b0, 1'b1, 1'b0);
		mgr.frame(1'b0, 2'h1, ADDR, 5'h01, 16'hFFFF, d);
		mgr.frame(1'b0, 2'h1, ADDR, 5'h02, 16'h0000, d);
		rdf(1'b0, ADDR, 5'h02);
		check(d, ID_H);
		rdf(1'b0, ADDR ^ 5'h01, 5'h01);
		check(d, 16'hFFFF);
		rd_status(1'b0);
		rd_status(1'b0);
		// bad opcode drops sync until a preamble
		mgr.frame(1'b0, 2'h0, ADDR, 5'h01, 16'h0000, d);
		rdf(1'b0, ADDR, 5'h01);
		check(d, 16'hFFFF);
		// soft reset clears the holds
		lev(1'b1, 1'b0, 1'b1);
		lev(1'b0, 1'b1, 1'b0);
		@(posedge clk_sys_in);
		soft_rst <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		soft_rst <= 1'b0;
		{h_rf, h_ll, h_jab} = 3'h0;
		rd_status(1'b1);
		// random event levels and reads
		for (int n = 0; n < 30; n++) begin
			r = $random(seed);
			lev(r[0], r[1] | r[2], r[3]);
			if (r[5:4] == 2'h0 || r[5:4] == 2'h1) begin
				rd_status(r[6]);
			end else begin
				rdf(r[6], ADDR, {3'h0, r[5:4]});
				check(d, id_val({3'h0, r[5:4]}));
			end
		end
		summarize();
	end
endmodule : tb_phy_basic_status_and_id_regs
